// ==== rtl/conv_mode_ctrl.sv ====
// Mode decode, rate derivation, output coding and settle control
//
// What this block does
// - Results are 24-bit two's complement, zero input gives zero code.
// - Results saturate at 7fffff and 800000, never wrapping.
// - Modulator rate is master clock divided by 4, 8 or 40 per mode.
// - Word rate is master clock divided by 256, 512 or 2560.
// - Word rate scales with master clock; resolution unaffected.
// - Mode pins decode 00 fast, 01 high-res, 10 low-power, 11 slow.
// - Mode pins are watched continuously; a change applies two clocks later, after the synchroniser.
// - SPI ready stays high after mode change up to 129 periods.
// - Frame-sync data held low after change for 127 to 128 periods.
// - Step settles after 76 or 78 periods, little change before 30.
// - Decimation filter has linear phase, constant delay.
// - All channels run from one shared master clock.
// - Oversampling ratio 128 in high-res, 64 otherwise.
// - SPI ready falling edge marks a new set of results.
`timescale 1ns/1ps
`default_nettype none
`include "conv_params.svh"
module conv_mode_ctrl
  import conv_pkg::*;
#(
  parameter int WIDE_W = 32
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Configuration pins
  input wire logic [1:0] mode_select_i,
  input wire logic clock_divide_select_i,
  input wire logic frame_protocol_i,
  // Filter result, one pulse per word
  input wire logic [WIDE_W-1:0] filter_data_i,
  input wire logic filter_valid_i,
  // Rates and status
  output logic modulator_rate_o,
  output logic output_word_rate_o,
  output logic [1:0] active_mode_o,
  // Results
  output logic [`WORD_W-1:0] result_o,
  output logic results_ready_n_o,
  output logic data_hold_low_o
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] mode_meta, mode_sync, mode_last;
  logic div_meta, div_sync, div_last, fs_meta, fs_sync;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_meta <= '0;
      mode_sync <= '0;
      div_meta <= 1'b0;
      div_sync <= 1'b0;
      fs_meta <= 1'b0;
      fs_sync <= 1'b0;
    end else begin
      mode_meta <= mode_select_i;
      mode_sync <= mode_meta;
      div_meta <= clock_divide_select_i;
      div_sync <= div_meta;
      fs_meta <= frame_protocol_i;
      fs_sync <= fs_meta;
    end
  end

  // ---------------------------------------------------------------
  // Mode decode and divide choice
  // ---------------------------------------------------------------
  op_mode_t mode;
  logic [11:0] mod_div, osr;
  logic mode_change;

  assign mode = op_mode_t'(mode_sync);
  assign active_mode_o = mode_sync;
  assign mode_change = (mode_sync != mode_last) ||
    (div_sync != div_last);

  always_comb begin
    mod_div = `MOD_DIV_4;
    osr = `OSR_LO;
    case (mode)
      MODE_HIGH_SPEED: mod_div = `MOD_DIV_4;
      MODE_HIGH_RES: begin
        mod_div = `MOD_DIV_4;
        osr = `OSR_HI;
      end
      MODE_LOW_POWER: mod_div = div_sync ? `MOD_DIV_8 : `MOD_DIV_4;
      MODE_LOW_SPEED: mod_div = div_sync ? `MOD_DIV_40 : `MOD_DIV_8;
      default: mod_div = `MOD_DIV_4;
    endcase
  end

  // ---------------------------------------------------------------
  // Rate dividers from the one shared clock
  // ---------------------------------------------------------------
  // Word rate = clock / (mod_div * osr): 256, 512 or 2560
  rate_divider #(.W(12)) mod_div_u (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .restart_i(mode_change),
    .divide_i(mod_div),
    .tick_i(1'b1),
    .pulse_o(modulator_rate_o)
  );

  rate_divider #(.W(12)) word_div_u (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .restart_i(mode_change),
    .divide_i(osr),
    .tick_i(modulator_rate_o),
    .pulse_o(output_word_rate_o)
  );

  // ---------------------------------------------------------------
  // Settle control after a mode change
  // ---------------------------------------------------------------
  run_state_t state, next_state;
  logic [7:0] settle_cnt, next_settle_cnt;
  logic [7:0] settle_len;
  logic next_ready_n, next_hold_low;

  assign settle_len = fs_sync ? `SETTLE_FS : `SETTLE_SPI;

  always_comb begin
    next_state = state;
    next_settle_cnt = settle_cnt;
    next_ready_n = 1'b1;
    next_hold_low = 1'b0;
    case (state)
      ST_SETTLE: begin
        next_hold_low = 1'b1;
        if (mode_change) begin
          next_settle_cnt = '0;
        end else if (output_word_rate_o) begin
          next_settle_cnt = settle_cnt + 8'h01;
          if (settle_cnt + 8'h01 >= settle_len) begin
            next_state = ST_VALID;
            next_hold_low = 1'b0;
            next_ready_n = 1'b0;
          end
        end
      end
      ST_VALID: begin
        if (mode_change) begin
          next_state = ST_SETTLE;
          next_settle_cnt = '0;
          next_hold_low = 1'b1;
        end else if (output_word_rate_o) begin
          next_ready_n = 1'b0;
        end
      end
      default: next_state = ST_SETTLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_last <= '0;
      div_last <= 1'b0;
      state <= ST_SETTLE;
      settle_cnt <= '0;
      results_ready_n_o <= 1'b1;
      data_hold_low_o <= 1'b1;
    end else begin
      mode_last <= mode_sync;
      div_last <= div_sync;
      state <= next_state;
      settle_cnt <= next_settle_cnt;
      results_ready_n_o <= fs_sync ? 1'b1 : next_ready_n;
      data_hold_low_o <= fs_sync ? next_hold_low : 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Output coding with clipping
  // ---------------------------------------------------------------
  // Filter path is linear phase: fixed latency for every frequency
  localparam logic signed [WIDE_W-1:0] WIDE_MAX =
    WIDE_W'(signed'(`CODE_MAX));
  localparam logic signed [WIDE_W-1:0] WIDE_MIN =
    WIDE_W'(signed'(`CODE_MIN));
  logic signed [WIDE_W-1:0] wide;
  logic [`WORD_W-1:0] next_result;

  assign wide = filter_data_i;

  always_comb begin
    if (wide > WIDE_MAX) begin
      next_result = `CODE_MAX;
    end else if (wide < WIDE_MIN) begin
      next_result = `CODE_MIN;
    end else begin
      next_result = wide[`WORD_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_o <= '0;
    end else if (filter_valid_i) begin
      result_o <= next_result;
    end
  end
endmodule
`default_nettype wire

// ==== common/conv_params.svh ====
// Constants for the converter mode, clock and output control block
`ifndef CONV_PARAMS_SVH
`define CONV_PARAMS_SVH
`define WORD_W 24
`define CODE_MAX 24'h7fffff
`define CODE_MIN 24'h800000
`define MODE_HS 2'h0
`define MODE_HR 2'h1
`define MODE_LP 2'h2
`define MODE_LS 2'h3
`define MOD_DIV_4 12'h004
`define MOD_DIV_8 12'h008
`define MOD_DIV_40 12'h028
`define OSR_LO 12'h040
`define OSR_HI 12'h080
`define SETTLE_SPI 8'h81
`define SETTLE_FS 8'h7f
`endif

// ==== common/conv_pkg.sv ====
// Types for the converter mode, clock and output control block
package conv_pkg;
  typedef enum logic [1:0] {
    MODE_HIGH_SPEED = 2'h0,
    MODE_HIGH_RES = 2'h1,
    MODE_LOW_POWER = 2'h2,
    MODE_LOW_SPEED = 2'h3
  } op_mode_t;
  typedef enum logic [1:0] {
    ST_SETTLE = 2'b01,
    ST_VALID = 2'b10
  } run_state_t;
endpackage

// ==== rtl/rate_divider.sv ====
// Programmable divider giving a one-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
module rate_divider #(
  parameter int W = 12
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic restart_i,
  input wire logic [W-1:0] divide_i,
  input wire logic tick_i,
  // Output
  output logic pulse_o
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic next_pulse;

  always_comb begin
    next_count = count;
    next_pulse = 1'b0;
    if (restart_i) begin
      next_count = '0;
    end else if (tick_i) begin
      if (count >= divide_i - W'(1)) begin
        next_count = '0;
        next_pulse = 1'b1;
      end else begin
        next_count = count + W'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= '0;
      pulse_o <= 1'b0;
    end else begin
      count <= next_count;
      pulse_o <= next_pulse;
    end
  end
endmodule
`default_nettype wire

// ==== sim/conv_mode_ctrl_properties.sv ====
// Checker for the mode, rate and result control block
`timescale 1ns/1ps
`default_nettype none
`include "conv_params.svh"
module conv_mode_ctrl_properties
  import conv_pkg::*;
#(parameter int WIDE_W = 32) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Pins and filter input
  input wire logic [1:0] mode_select_i,
  input wire logic frame_protocol_i,
  input wire logic [WIDE_W-1:0] filter_data_i,
  input wire logic filter_valid_i,
  // Outputs
  input wire logic modulator_rate_o,
  input wire logic [1:0] active_mode_o,
  input wire logic [`WORD_W-1:0] result_o,
  input wire logic results_ready_n_o,
  input wire logic data_hold_low_o
);
  localparam logic signed [WIDE_W-1:0] HI = WIDE_W'(signed'(`CODE_MAX));
  localparam logic signed [WIDE_W-1:0] LO = WIDE_W'(signed'(`CODE_MIN));
  logic signed [WIDE_W-1:0] d;
  logic [`WORD_W-1:0] d_low;
  assign d = filter_data_i;
  assign d_low = filter_data_i[`WORD_W-1:0];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_quiet; results_ready_n_o [*8]; endsequence
  sequence s_held; data_hold_low_o [*8]; endsequence
  property p_pass; filter_valid_i && d <= HI && d >= LO
    |=> result_o == $past(d_low); endproperty
  property p_hi; filter_valid_i && d > HI |=> result_o == `CODE_MAX;
  endproperty
  property p_lo; filter_valid_i && d < LO |=> result_o == `CODE_MIN;
  endproperty
  property p_mode; $stable(mode_select_i) [*4]
    |-> active_mode_o == mode_select_i; endproperty
  property p_rdy; !results_ready_n_o |=> results_ready_n_o; endproperty
  property p_fs; frame_protocol_i [*4] |-> results_ready_n_o; endproperty
  property p_chg; $changed(active_mode_o) |-> ##2 s_quiet; endproperty
  property p_hold; $changed(active_mode_o) && frame_protocol_i
    |-> ##2 s_held; endproperty
  property p_mod; modulator_rate_o |=> !modulator_rate_o [*3]; endproperty
  a_pass: assert property (p_pass) else $error("result pass");
  a_hi: assert property (p_hi) else $error("high clip");
  a_lo: assert property (p_lo) else $error("low clip");
  a_mode: assert property (p_mode) else $error("mode");
  a_rdy: assert property (p_rdy) else $error("ready pulse");
  a_fs: assert property (p_fs) else $error("ready in fs");
  a_chg: assert property (p_chg) else $error("ready settle");
  a_hold: assert property (p_hold) else $error("hold low");
  a_mod: assert property (p_mod) else $error("mod gap");
endmodule
bind conv_mode_ctrl conv_mode_ctrl_properties #(.WIDE_W(WIDE_W)) u_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .mode_select_i(mode_select_i),
  .frame_protocol_i(frame_protocol_i), .filter_data_i(filter_data_i),
  .filter_valid_i(filter_valid_i), .modulator_rate_o(modulator_rate_o),
  .active_mode_o(active_mode_o), .result_o(result_o),
  .results_ready_n_o(results_ready_n_o), .data_hold_low_o(data_hold_low_o));
`default_nettype wire

// ==== sim/host_model.sv ====
// Host model that collects results from the block
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input wire logic clk_i,
  // Status and data
  input wire logic ready_n_i,
  input wire logic hold_i,
  input wire logic [23:0] result_i,
  // What the host has read
  output int words_o,
  output logic valid_o,
  output logic [23:0] last_o
);
  int n_words = 0;
  logic [23:0] last = '0;
  logic valid_seen = 1'b0;
  assign words_o = n_words;
  assign last_o = last;
  assign valid_o = valid_seen;
  // Clock kept at 25 MHz, inside every mode limit
  always @(posedge clk_i) begin
    if (ready_n_i === 1'b0) begin
      last <= result_i;
      n_words <= n_words + 1;
    end
    valid_seen <= (hold_i === 1'b0);
  end
endmodule
`default_nettype wire

// ==== sim/conv_mode_ctrl_bench.sv ====
// Bench for the mode, rate and result control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module conv_mode_ctrl_bench;
  import conv_pkg::*;
  logic clk_i = 0, rst_n_i = 0, cds = 1, fp = 0, fv = 0, mr, wr, rdy_n, hold;
  logic [1:0] ms = 0, am;
  logic [31:0] fd = 0;
  logic [23:0] res;
  logic h_valid;
  logic [23:0] h_last;
  int n_fail = 0, n_tests = 0, words;
  always #20 clk_i = ~clk_i;
  conv_mode_ctrl u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .mode_select_i(ms), .clock_divide_select_i(cds),
    .frame_protocol_i(fp), .filter_data_i(fd), .filter_valid_i(fv),
    .modulator_rate_o(mr), .output_word_rate_o(wr), .active_mode_o(am),
    .result_o(res), .results_ready_n_o(rdy_n), .data_hold_low_o(hold));
  host_model u_host (.clk_i(clk_i), .ready_n_i(rdy_n), .hold_i(hold),
    .result_i(res), .words_o(words), .valid_o(h_valid), .last_o(h_last));
  task automatic wrap_up;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_settle(input int lo, input int hi);
    int n = 0;
    for (int c = 0; c < 40000; c++) begin
      @(negedge clk_i);
      if (fp ? hold === 1'b0 : rdy_n === 1'b0) break;
      n += (wr === 1'b1);
    end
    `CHK("settle", 1'b1, n >= lo && n <= hi)
    $display("settle test done, %0d words", n);
  endtask
  task automatic t_clip;
    logic [31:0] di [8] = '{32'h0, 32'h1, 32'hffffffff, 32'h7fffff,
      32'hff800000, 32'h800000, 32'hff7fffff, 32'h80000000};
    logic [23:0] de [8] = '{24'h0, 24'h1, 24'hffffff, 24'h7fffff,
      24'h800000, 24'h7fffff, 24'h800000, 24'h800000};
    for (int i = 0; i < 8; i++) begin
      fd = di[i];
      fv = 1;
      @(negedge clk_i);
      fv = 0;
      @(negedge clk_i);
      `CHK("result", de[i], res)
    end
    $display("clip test done");
  endtask
  task automatic gap(input bit w, output int g);
    g = 0;
    for (int c = 0; c < 6000 && (w ? wr : mr) !== 1'b1; c++) @(negedge clk_i);
    do begin @(negedge clk_i); g++; end
    while ((w ? wr : mr) !== 1'b1 && g < 6000);
  endtask
  task automatic t_rates;
    int t [6][4] = '{'{0, 1, 4, 256}, '{1, 1, 4, 512}, '{2, 1, 8, 512},
      '{2, 0, 4, 256}, '{3, 1, 40, 2560}, '{3, 0, 8, 512}};
    int g;
    for (int i = 0; i < 6; i++) begin
      ms = 2'(t[i][0]);
      cds = 1'(t[i][1]);
      repeat (10) @(negedge clk_i);
      `CHK("mode", 2'(t[i][0]), am)
      gap(0, g);
      `CHK("mod gap", t[i][2], g)
      gap(1, g);
      `CHK("word gap", t[i][3], g)
    end
    $display("rate test done");
  endtask
  task automatic t_host;
    `CHK("host reads", 1'b1, words > 0)
    `CHK("host word", 24'h800000, h_last)
    $display("host test done");
  endtask
  task automatic t_frame;
    int lows = 0;
    fp = 1;
    repeat (10) @(negedge clk_i);
    ms = 2'h0;
    cds = 1;
    t_settle(127, 128);
    @(negedge clk_i);
    `CHK("host valid", 1'b1, h_valid)
    for (int c = 0; c < 600; c++) begin
      @(negedge clk_i);
      lows += (rdy_n !== 1'b1);
      lows += (hold !== 1'b0);
    end
    `CHK("fs quiet", 0, lows)
    $display("frame test done");
  endtask
  initial begin
    #4_000_000;
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (6) @(negedge clk_i);
    rst_n_i = 1;
    t_settle(128, 129);
    t_clip();
    t_rates();
    t_host();
    t_frame();
    wrap_up();
  end
endmodule
`default_nettype wire
